// ---- bea_core.sv ----
// Bulk endpoint busy/arm handshake, endpoint interrupts and autovector.
// Assumes a synchronous token port from the USB engine, an 8-bit register
// port with read data one cycle late, and a code fetch path to patch.
//
// Overview of operation
// - IN busy flag readable at bit 1
// - OUT busy flag readable at bit 1
// - busy means core owns buffer
// - IN count write arms, sets length
// - OUT count write arms, value ignored
// - 64-byte buffer, 40h sends whole packet
// - all sources share one interrupt, entry 43h
// - autovector replaces byte at 45h
// - vector codes step by four
// - autovector off leaves byte untouched
// - vector register names current source
// - per-endpoint enable and request bits
// - clear register write drops shared request
// - reset default config includes endpoint 2
// - request bits clear where one written
// - resets arm OUT endpoints 1 to 7
`timescale 1ns/1ps
module bea_core #(
  parameter int NUM_EP = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdData,
  // USB engine side
  input  wire logic        inTokenValid,
  input  wire logic [2:0]  inTokenEp,
  output logic             inAck,
  output logic             inNak,
  output logic      [6:0]  inLen,
  input  wire logic        outPktValid,
  input  wire logic [2:0]  outPktEp,
  input  wire logic [6:0]  outPktLen,
  output logic             outAck,
  output logic             outNak,
  input  wire logic        setupDataAvailable,
  input  wire logic        startOfFrame,
  input  wire logic        setupTokenSeen,
  input  wire logic        suspendEvent,
  input  wire logic        busResetEvent,
  // Processor side
  input  wire logic [15:0] fetchAddr,
  input  wire logic [7:0]  fetchData,
  output logic      [7:0]  fetchOut,
  output logic      [15:0] intVectorAddr,
  output logic      [7:0]  epValid,
  output logic             sharedUsbInterrupt
);
  localparam int NREQ = bea_pkg::NUM_EVT + 2 * NUM_EP;

  // Elaboration guard: the bank decode and 8-bit request registers cap NUM_EP
  if (NUM_EP < 2 || NUM_EP > 8) begin : g_bad_num_ep
    $error("bea_core: NUM_EP must lie between 2 and 8");
  end

  logic [NUM_EP-1:0] inBusy;
  logic [NUM_EP-1:0] outBusy;
  logic [NUM_EP-1:0] inIrq;
  logic [NUM_EP-1:0] outIrq;
  logic [NUM_EP-1:0] inIen;
  logic [NUM_EP-1:0] outIen;
  logic [6:0]        inCnt [NUM_EP];
  logic [6:0]        outCnt [NUM_EP];
  logic [5:0]        evtSt;
  logic [5:0]        evtIen;
  logic [7:0]        ctrl;
  logic [NREQ-1:0]   reqsPrev;

  // Address decode; per-endpoint banks use the low three address bits
  wire [2:0] idx     = regAddr[2:0];
  wire       idxOk   = (32'(idx) < NUM_EP);
  wire [4:0] bank    = regAddr[7:bea_pkg::BANK_LSB];
  wire       inCsSel  = (bank == bea_pkg::OFS_IN_CS[7:3]) && idxOk;
  wire       outCsSel = (bank == bea_pkg::OFS_OUT_CS[7:3]) && idxOk;
  wire       inBcSel  = (bank == bea_pkg::OFS_IN_BC[7:3]) && idxOk;
  wire       outBcSel = (bank == bea_pkg::OFS_OUT_BC[7:3]) && idxOk;
  wire       inIrqWr  = regWr && (regAddr == bea_pkg::OFS_IN_IRQ);
  wire       outIrqWr = regWr && (regAddr == bea_pkg::OFS_OUT_IRQ);
  wire       inBcWr   = regWr && inBcSel;
  wire       outBcWr  = regWr && outBcSel;
  wire       evtRd    = regRd && (regAddr == bea_pkg::OFS_EVT_ST);
  wire       irqClrWr = regWr && (regAddr == bea_pkg::OFS_IRQ_CLR);
  wire       autovector_enable     = ctrl[bea_pkg::AUTOVECTOR_ENABLE_BIT];

  // Host tokens: only an armed (busy) endpoint answers, others NAK
  wire       inTokOk  = (32'(inTokenEp) < NUM_EP);
  wire       outTokOk = (32'(outPktEp) < NUM_EP);
  wire       inSend   = inTokenValid && inTokOk && inBusy[inTokenEp];
  wire       outTake  = outPktValid && outTokOk && outBusy[outPktEp];

  // Written IN count is clamped to one buffer's worth
  wire [6:0] inCntWr = (regWrData > 8'(bea_pkg::MAX_PKT)) ?
                       bea_pkg::MAX_PKT : regWrData[6:0];

  // Per-endpoint next values for busy and request flags; sets win clears
  wire [NUM_EP-1:0] next_inBusy;
  wire [NUM_EP-1:0] next_outBusy;
  wire [NUM_EP-1:0] next_inIrq;
  wire [NUM_EP-1:0] next_outIrq;
  wire [NREQ-1:0]   reqs;

  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    wire inArm  = inBcWr && (idx == 3'(e));
    wire outArm = (outBcWr && (idx == 3'(e))) || (busResetEvent && e != 0);
    wire inDone = inSend && (inTokenEp == 3'(e));
    wire outGot = outTake && (outPktEp == 3'(e));
    assign next_inBusy[e]  = inArm | (inBusy[e] & ~inDone);
    assign next_outBusy[e] = outArm | (outBusy[e] & ~outGot);
    assign next_inIrq[e]   = inDone | (inIrq[e] & ~(inIrqWr & regWrData[e]));
    assign next_outIrq[e]  = outGot | (outIrq[e] & ~(outIrqWr & regWrData[e]));
    assign reqs[bea_pkg::NUM_EVT + 2 * e]     = inIrq[e] & inIen[e];
    assign reqs[bea_pkg::NUM_EVT + 2 * e + 1] = outIrq[e] & outIen[e];
  end
  assign reqs[bea_pkg::NUM_EVT-1:0] = evtSt & evtIen;

  // Events pending together: the picker hands back the lowest code
  wire [7:0] vecCode;
  wire       anyReq;
  bea_vec_pick #(
    .N    (NREQ)
  ) u_pick (
    .req  (reqs),
    .code (vecCode),
    .any  (anyReq)
  );

  // Event status; read clears, but a new event in that cycle survives
  wire [5:0] evtIn = {1'b0, busResetEvent, suspendEvent, setupTokenSeen,
                      startOfFrame, setupDataAvailable};
  wire [5:0] next_evtSt = evtIn | (evtSt & ~{6{evtRd}});

  // Shared request rises on any newly pending source; clear write drops it
  wire newReq = |(reqs & ~reqsPrev);
  wire next_usbIrq = newReq | (sharedUsbInterrupt & ~irqClrWr);

  // Read mux
  wire [7:0] rdMux =
    inCsSel  ? (8'(inBusy[idx]) << bea_pkg::BUSY_BIT) :
    outCsSel ? (8'(outBusy[idx]) << bea_pkg::BUSY_BIT) :
    inBcSel  ? {1'b0, inCnt[idx]} :
    outBcSel ? {1'b0, outCnt[idx]} :
    (regAddr == bea_pkg::OFS_IN_IRQ)   ? 8'(inIrq) :
    (regAddr == bea_pkg::OFS_OUT_IRQ)  ? 8'(outIrq) :
    (regAddr == bea_pkg::OFS_IN_IEN)   ? 8'(inIen) :
    (regAddr == bea_pkg::OFS_OUT_IEN)  ? 8'(outIen) :
    (regAddr == bea_pkg::OFS_EVT_ST)   ? {2'b00, evtSt} :
    (regAddr == bea_pkg::OFS_EVT_IEN)  ? {2'b00, evtIen} :
    (regAddr == bea_pkg::OFS_INTERRUPT_VECTOR_REG)     ? vecCode :
    (regAddr == bea_pkg::OFS_CTRL)     ? ctrl :
    (regAddr == bea_pkg::OFS_EP_VALID) ? epValid : 8'h00;

  // Fetch patch: only the low jump target byte is ever replaced
  wire       patchHit = autovector_enable && (fetchAddr == bea_pkg::VEC_LOW_ADDR);
  wire [7:0] next_fetchOut = patchHit ? vecCode : fetchData;

  // Flags and handshake answers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inBusy   <= '0;
      outBusy  <= bea_pkg::OUT_ARM_RESET[NUM_EP-1:0];
      inIrq    <= '0;
      outIrq   <= '0;
      evtSt    <= '0;
      reqsPrev <= '0;
      sharedUsbInterrupt <= 1'b0;
      inAck    <= 1'b0;
      inNak    <= 1'b0;
      outAck   <= 1'b0;
      outNak   <= 1'b0;
      inLen    <= '0;
    end else begin
      inBusy   <= next_inBusy;
      outBusy  <= next_outBusy;
      inIrq    <= next_inIrq;
      outIrq   <= next_outIrq;
      evtSt    <= next_evtSt;
      reqsPrev <= reqs;
      sharedUsbInterrupt <= next_usbIrq;
      inAck    <= inSend;
      inNak    <= inTokenValid && !inSend;
      outAck   <= outTake;
      outNak   <= outPktValid && !outTake;
      inLen    <= inSend ? inCnt[inTokenEp] : '0;
    end
  end

  // Byte counts; OUT count records what arrived, not what was written
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NUM_EP; i++) begin
        inCnt[i]  <= '0;
        outCnt[i] <= '0;
      end
    end else begin
      if (inBcWr) inCnt[idx] <= inCntWr;
      if (outTake) outCnt[outPktEp] <= outPktLen;
    end
  end

  // Software control registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inIen   <= '0;
      outIen  <= '0;
      evtIen  <= '0;
      ctrl    <= bea_pkg::CTRL_RESET;
      epValid <= bea_pkg::EP_VALID_RESET;
    end else if (regWr) begin
      if (regAddr == bea_pkg::OFS_IN_IEN) inIen <= regWrData[NUM_EP-1:0];
      if (regAddr == bea_pkg::OFS_OUT_IEN) outIen <= regWrData[NUM_EP-1:0];
      if (regAddr == bea_pkg::OFS_EVT_IEN) evtIen <= regWrData[5:0];
      if (regAddr == bea_pkg::OFS_CTRL) ctrl <= regWrData;
      if (regAddr == bea_pkg::OFS_EP_VALID) epValid <= regWrData;
    end
  end

  // Read data, fetch patch and fixed entry address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData     <= 8'h00;
      fetchOut      <= 8'h00;
      intVectorAddr <= bea_pkg::VEC_JMP_ADDR;
    end else begin
      regRdData     <= regRd ? rdMux : 8'h00;
      fetchOut      <= next_fetchOut;
      intVectorAddr <= bea_pkg::VEC_JMP_ADDR;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_in_arm_busy: assert property (
    inBcWr |=> inBusy[$past(idx)])
    else $error("IN count write did not arm the endpoint");

  chk_out_arm_busy: assert property (
    outBcWr |=> outBusy[$past(idx)])
    else $error("OUT count write did not set busy");

  chk_in_nak_idle: assert property (
    inTokenValid && inTokOk && !inBusy[inTokenEp] |=> inNak && !inAck)
    else $error("IN token on idle endpoint was not refused");

  chk_in_full_len: assert property (
    inBcWr && regWrData == 8'h40 ##1 inTokenValid && inTokenEp == $past(idx)
    && !inBcWr |=> inAck && inLen == bea_pkg::MAX_PKT)
    else $error("Count 40h did not send a whole buffer");

  chk_busy_read: assert property (
    regRd && inCsSel && !inTokenValid && !regWr
    |=> regRdData[bea_pkg::BUSY_BIT] == $past(inBusy[idx]))
    else $error("IN busy flag not shown at bit 1");

  chk_irq_keep_zero: assert property (
    inIrqWr |=> ((inIrq & $past(inIrq) & ~$past(regWrData[NUM_EP-1:0]))
                 == ($past(inIrq) & ~$past(regWrData[NUM_EP-1:0]))))
    else $error("Request bit written with zero was lost");

  chk_vec_patch: assert property (
    patchHit |=> fetchOut == $past(vecCode))
    else $error("Autovector byte not inserted");

  chk_vec_pass: assert property (
    !autovector_enable |=> fetchOut == $past(fetchData))
    else $error("Fetch byte altered with autovector off");

  chk_irq_clear: assert property (
    irqClrWr && !newReq |=> !sharedUsbInterrupt)
    else $error("Clear write did not drop shared request");

  chk_bus_rearm: assert property (
    busResetEvent |=> &outBusy[NUM_EP-1:1])
    else $error("Bus reset did not arm OUT endpoints");

  chk_out_busy_read: assert property (
    regRd && outCsSel && !outPktValid && !regWr
    |=> regRdData[bea_pkg::BUSY_BIT] == $past(outBusy[idx]))
    else $error("OUT busy flag not shown at bit 1");

  chk_in_ack_free: assert property (
    inSend && !inBcWr |=> inAck && !inBusy[$past(inTokenEp)])
    else $error("Sent IN endpoint still busy");

  chk_out_nak_idle: assert property (
    outPktValid && outTokOk && !outBusy[outPktEp] |=> outNak && !outAck)
    else $error("OUT packet on idle endpoint was not refused");

  cov_in_ack: cover property (inAck);
  cov_out_ack: cover property (outAck);
  cov_patch: cover property (patchHit && anyReq);
  cov_irq_rise: cover property ($rose(sharedUsbInterrupt));
  cov_full_len: cover property (inAck && inLen == bea_pkg::MAX_PKT);
endmodule

// ---- bea_pkg.sv ----
// Constants shared by the bulk endpoint arm and autovector logic.
// Assumes an 8-bit register port and up to eight bulk endpoints.
package bea_pkg;
  // Register offsets; per-endpoint banks take eight consecutive slots
  localparam logic [7:0] OFS_IN_CS    = 8'h00;
  localparam logic [7:0] OFS_OUT_CS   = 8'h08;
  localparam logic [7:0] OFS_IN_BC    = 8'h10;
  localparam logic [7:0] OFS_OUT_BC   = 8'h18;
  localparam logic [7:0] OFS_IN_IRQ   = 8'h20;
  localparam logic [7:0] OFS_OUT_IRQ  = 8'h21;
  localparam logic [7:0] OFS_IN_IEN   = 8'h22;
  localparam logic [7:0] OFS_OUT_IEN  = 8'h23;
  localparam logic [7:0] OFS_EVT_ST   = 8'h24;
  localparam logic [7:0] OFS_EVT_IEN  = 8'h25;
  localparam logic [7:0] OFS_INTERRUPT_VECTOR_REG     = 8'h26;
  localparam logic [7:0] OFS_CTRL     = 8'h27;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
  localparam logic [7:0] OFS_EP_VALID = 8'h29;
  // Field positions
  localparam int BUSY_BIT = 1;
  localparam int AUTOVECTOR_ENABLE_BIT = 0;
  localparam int BANK_LSB = 3;
  // Event sources ahead of the endpoint pairs
  localparam int EVT_SETUP_DATA_AVAILABLE = 0;
  localparam int EVT_SOF   = 1;
  localparam int EVT_SETUP_TOKEN_SEEN = 2;
  localparam int EVT_SUSP  = 3;
  localparam int EVT_BRST  = 4;
  localparam int NUM_EVT   = 6;
  // Vector figures
  localparam logic [15:0] VEC_JMP_ADDR = 16'h0043;
  localparam logic [15:0] VEC_LOW_ADDR = 16'h0045;
  localparam int          VEC_STEP     = 4;
  // Packet size and reset values
  localparam logic [6:0] MAX_PKT        = 7'h40;
  localparam logic [7:0] OUT_ARM_RESET  = 8'hFE;
  localparam logic [7:0] EP_VALID_RESET = 8'h04;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
endpackage

// ---- bea_vec_pick.sv ----
// Priority picker for the shared USB interrupt vector.
// Assumes request bit i maps to vector code i times the vector step.
`timescale 1ns/1ps
module bea_vec_pick #(
  parameter int N = 22
) (
  input  wire logic [N-1:0] req,
  output logic      [7:0]   code,
  output logic              any
);
  // Elaboration guard: every code must fit the single patched byte
  if (N < 1 || N * bea_pkg::VEC_STEP > 256) begin : g_bad_n
    $error("bea_vec_pick: request count does not fit the code byte");
  end

  // Lowest index wins, so scan downward and let the last hit stand
  always_comb begin
    code = 8'h00;
    any  = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        code = 8'(i * bea_pkg::VEC_STEP);
        any  = 1'b1;
      end
    end
  end
endmodule

// ---- bea_usb_host.sv ----
// USB host stand-in that issues bulk IN tokens and OUT packets to the core.
// Assumes the core answers each request on the same edge that takes it.
`timescale 1ns/1ps
module bea_usb_host (
  input  wire logic       clk,
  input  wire logic       inAck,
  input  wire logic       inNak,
  input  wire logic [6:0] inLen,
  input  wire logic       outAck,
  output logic            inTokenValid,
  output logic      [2:0] inTokenEp,
  output logic            outPktValid,
  output logic      [2:0] outPktEp,
  output logic      [6:0] outPktLen
);
  // Quiet lines at time zero
  initial begin
    inTokenValid = 1'b0;
    inTokenEp    = 3'h0;
    outPktValid  = 1'b0;
    outPktEp     = 3'h0;
    outPktLen    = 7'h00;
  end
  // One IN token; fields are inverted afterwards so stale values never pass as live
  task automatic sendIn(input logic [2:0] ep, output logic ack, output logic nak,
                        output logic [6:0] len);
    @(posedge clk);
    inTokenValid <= 1'b1;
    inTokenEp    <= ep;
    @(posedge clk);
    inTokenValid <= 1'b0;
    inTokenEp    <= ~ep;
    #1;
    ack = inAck;
    nak = inNak;
    len = inLen;
  endtask
  // One OUT packet of the given length
  task automatic sendOut(input logic [2:0] ep, input logic [6:0] n, output logic ack);
    @(posedge clk);
    outPktValid <= 1'b1;
    outPktEp    <= ep;
    outPktLen   <= n;
    @(posedge clk);
    outPktValid <= 1'b0;
    outPktEp    <= ~ep;
    outPktLen   <= ~n;
    #1;
    ack = outAck;
  endtask
endmodule

// ---- bulk_endpoint_arm_and_autovector_tb.sv ----
// Self-checking bench for the bulk endpoint arm and autovector core.
// Assumes the host stand-in model and the core's default endpoint count.
`timescale 1ns/1ps
module bulk_endpoint_arm_and_autovector_tb;
  logic        clk;
  logic        reset;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic        inTokenValid;
  logic [2:0]  inTokenEp;
  logic        inAck;
  logic        inNak;
  logic [6:0]  inLen;
  logic        outPktValid;
  logic [2:0]  outPktEp;
  logic [6:0]  outPktLen;
  logic        outAck;
  logic        outNak;
  logic [4:0]  evt;
  logic [15:0] fetchAddr;
  logic [7:0]  fetchData;
  logic [7:0]  fetchOut;
  logic [15:0] intVectorAddr;
  logic [7:0]  epValid;
  logic        sharedUsbInterrupt;
  logic        ack;
  logic        nak;
  logic [6:0]  len;
  int          miscompares;
  int          tests_run;
  int          cycles;

  bea_core u_bea_core (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .inTokenValid(inTokenValid),
    .inTokenEp(inTokenEp), .inAck(inAck), .inNak(inNak), .inLen(inLen),
    .outPktValid(outPktValid), .outPktEp(outPktEp), .outPktLen(outPktLen), .outAck(outAck),
    .outNak(outNak), .setupDataAvailable(evt[0]), .startOfFrame(evt[1]),
    .setupTokenSeen(evt[2]),
    .suspendEvent(evt[3]), .busResetEvent(evt[4]), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .fetchOut(fetchOut), .intVectorAddr(intVectorAddr),
    .epValid(epValid), .sharedUsbInterrupt(sharedUsbInterrupt));
  bea_usb_host u_bea_usb_host (.clk(clk), .inAck(inAck), .inNak(inNak), .inLen(inLen),
    .outAck(outAck), .inTokenValid(inTokenValid), .inTokenEp(inTokenEp),
    .outPktValid(outPktValid), .outPktEp(outPktEp), .outPktLen(outPktLen));

  // Free-running clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // Register strobes last one cycle; a gap cycle avoids double drives
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdChk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, regRdData});
  endtask
  task automatic fetchChk(input logic [15:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    fetchAddr <= a;
    fetchData <= d;
    @(posedge clk);
    #1;
    chk("fetchOut", {8'h00, exp}, {8'h00, fetchOut});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    {regAddr, regWrData, regWr, regRd, evt, fetchAddr, fetchData} = '0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Reset state: OUT 1..7 armed, endpoint 2 configured
    rdChk("inCs2", bea_pkg::OFS_IN_CS + 8'h02, 8'h00);
    chk("intVectorAddr", 16'h0043, intVectorAddr);
    chk("epValid", 16'h0004, {8'h00, epValid});
    for (int e = 0; e < 8; e++) begin
      rdChk("outCsReset", bea_pkg::OFS_OUT_CS + 8'(e), (e == 0) ? 8'h00 : 8'h02);
    end
    // IN: full packet, refusal once consumed, then a short packet
    wr(bea_pkg::OFS_IN_BC + 8'h02, 8'h40);
    rdChk("inCs2Armed", bea_pkg::OFS_IN_CS + 8'h02, 8'h02);
    u_bea_usb_host.sendIn(3'h2, ack, nak, len);
    chk("inAck", 16'h0001, {15'h0, ack});
    chk("inLenFull", 16'h0040, {9'h0, len});
    rdChk("inCs2Idle", bea_pkg::OFS_IN_CS + 8'h02, 8'h00);
    u_bea_usb_host.sendIn(3'h2, ack, nak, len);
    chk("inNak", 16'h0001, {15'h0, nak});
    wr(bea_pkg::OFS_IN_BC + 8'h03, 8'h05);
    u_bea_usb_host.sendIn(3'h3, ack, nak, len);
    chk("inLenShort", 16'h0005, {9'h0, len});
    // Request bits clear only where a one is written
    rdChk("inIrq", bea_pkg::OFS_IN_IRQ, 8'h0C);
    wr(bea_pkg::OFS_IN_IRQ, 8'h04);
    rdChk("inIrqW1c", bea_pkg::OFS_IN_IRQ, 8'h08);
    wr(bea_pkg::OFS_IN_IRQ, 8'h08);
    // OUT: reset arming takes one packet, then refuses until rearmed
    u_bea_usb_host.sendOut(3'h2, 7'h0A, ack);
    chk("outAck", 16'h0001, {15'h0, ack});
    rdChk("outCs2Idle", bea_pkg::OFS_OUT_CS + 8'h02, 8'h00);
    u_bea_usb_host.sendOut(3'h2, 7'h0A, ack);
    chk("outRefused", 16'h0000, {15'h0, ack});
    chk("outNak", 16'h0001, {15'h0, outNak});
    wr(bea_pkg::OFS_OUT_BC + 8'h02, 8'hA5);
    rdChk("outCs2Armed", bea_pkg::OFS_OUT_CS + 8'h02, 8'h02);
    rdChk("outIrq", bea_pkg::OFS_OUT_IRQ, 8'h04);
    wr(bea_pkg::OFS_OUT_IRQ, 8'hFF);
    // Shared interrupt, vector register and byte patching
    wr(bea_pkg::OFS_IN_IEN, 8'hFF);
    wr(bea_pkg::OFS_OUT_IEN, 8'hFF);
    wr(bea_pkg::OFS_EVT_IEN, 8'h1F);
    wr(bea_pkg::OFS_IN_BC + 8'h06, 8'h40);
    u_bea_usb_host.sendIn(3'h6, ack, nak, len);
    repeat (2) @(posedge clk);
    #1 chk("sharedIrq", 16'h0001, {15'h0, sharedUsbInterrupt});
    rdChk("ivecIn6", bea_pkg::OFS_INTERRUPT_VECTOR_REG, 8'h48);
    fetchChk(bea_pkg::VEC_LOW_ADDR, 8'h9A, 8'h9A);
    wr(bea_pkg::OFS_CTRL, 8'h01);
    fetchChk(bea_pkg::VEC_LOW_ADDR, 8'h9A, 8'h48);
    fetchChk(16'h0044, 8'h03, 8'h03);
    wr(bea_pkg::OFS_IRQ_CLR, 8'h00);
    @(posedge clk);
    #1 chk("sharedIrqClr", 16'h0000, {15'h0, sharedUsbInterrupt});
    wr(bea_pkg::OFS_IN_IRQ, 8'h40);
    // Events win over a pending endpoint request on their lower codes
    u_bea_usb_host.sendOut(3'h5, 7'h01, ack);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      evt <= 5'h01 << i;
      @(posedge clk);
      evt <= 5'h00;
      rdChk("ivecEvent", bea_pkg::OFS_INTERRUPT_VECTOR_REG, 8'(4 * i));
      rdChk("evtStatus", bea_pkg::OFS_EVT_ST, 8'h01 << i);
    end
    rdChk("outCs5BusReset", bea_pkg::OFS_OUT_CS + 8'h05, 8'h02);
    wr(bea_pkg::OFS_OUT_IRQ, 8'h20);
    // Every endpoint code, IN then OUT
    for (int e = 0; e < 8; e++) begin
      wr(bea_pkg::OFS_IN_BC + 8'(e), 8'h01);
      u_bea_usb_host.sendIn(3'(e), ack, nak, len);
      rdChk("ivecIn", bea_pkg::OFS_INTERRUPT_VECTOR_REG, 8'h18 + 8'(8 * e));
      wr(bea_pkg::OFS_IN_IRQ, 8'h01 << e);
      wr(bea_pkg::OFS_OUT_BC + 8'(e), 8'h00);
      u_bea_usb_host.sendOut(3'(e), 7'h40, ack);
      chk("outRearmed", 16'h0001, {15'h0, ack});
      rdChk("ivecOut", bea_pkg::OFS_INTERRUPT_VECTOR_REG, 8'h1C + 8'(8 * e));
      wr(bea_pkg::OFS_OUT_IRQ, 8'h01 << e);
    end
    // Token right behind the count write: the fresh arm must already answer
    fork
      wr(bea_pkg::OFS_IN_BC + 8'h07, 8'h40);
      begin
        @(posedge clk);
        u_bea_usb_host.sendIn(3'h7, ack, nak, len);
      end
    join
    chk("inAckBackToBack", 16'h0001, {15'h0, ack});
    chk("inLenBackToBack", 16'h0040, {9'h0, len});
    complete_run();
  end
endmodule
